// File: rtl/msq_seq_ctrl.sv
`include "msq_consts.svh"
module msq_seq_ctrl
    import msq_pkg::*;
(
    // Clock and reset
    input  logic                 sys_clk,
    input  logic                 rst_n,
    // Register port
    input  logic [3:0]           reg_addr,
    input  logic [31:0]          reg_wdata,
    input  logic                 reg_wr,
    input  logic                 reg_rd,
    output logic [31:0]          reg_rdata,
    // Barrier and flush from issue
    input  logic                 bar_valid,
    input  logic [2:0]           bar_cmask,
    input  logic [3:0]           bar_mmask,
    input  logic                 flush_valid,
    input  logic [`MSQ_DW_W-1:0] flush_dw,
    // Memory request from issue
    input  logic                 mem_req_valid,
    input  logic                 mem_req_load,
    input  logic                 mem_req_store,
    input  logic [7:0]           mem_req_asi,
    input  logic [`MSQ_DW_W-1:0] mem_req_dw,
    input  logic                 side_effect_page_bit,
    input  logic                 nonfault_only_page_bit,
    input  logic                 page_cacheable,
    // Store buffer and memory status
    input  logic                 sb_empty,
    input  logic                 sb_addr_match,
    input  logic                 mem_idle,
    input  logic                 pipe_idle,
    input  logic                 fault_pending,
    // Answer to the request
    output logic                 mem_go,
    output logic                 mem_fault,
    output logic                 mem_retry,
    output logic                 st_merge,
    // Ordering controls
    output logic                 no_fwd,
    output logic                 mem_hold,
    output logic                 instr_hold,
    output logic                 pipe_flush,
    output logic                 icache_inv,
    output logic                 icache_inv_all,
    output logic [`MSQ_DW_W-1:0] icache_inv_dw
);
    msq_top_t   r, n;
    msq_state_t bar_tgt;
    msq_state_t eff;
    logic       drain_done;
    logic       all_done;
    logic       fin;
    logic       blocked;
    logic       nf_is;
    logic       nf_fault;
    logic       merge_ok;
    logic       st_go;
    logic       fence;

    // Strongest sequencing asked for by one barrier
    function automatic msq_state_t bar_map(
        input logic [2:0] cm,
        input logic [3:0] mm,
        input logic       promo
    );
        msq_state_t s;
        s = ST_IDLE;
        if (cm[`MSQ_CM_LOOK])
            s = ST_LOOK;
        // Store-before-load ordering needs the stores drained
        if (cm[`MSQ_CM_ISSUE] || mm[`MSQ_MM_STLD])
            s = ST_DRAIN;
        if (cm[`MSQ_CM_SYNC])
            s = ST_SYNC;
        // Cheaper to verify, costs some throughput
        if (promo && s != ST_IDLE)
            s = ST_SYNC;
        return s;
    endfunction

    function automatic msq_state_t stronger(input msq_state_t a, input msq_state_t b);
        return (b > a) ? b : a;
    endfunction

    assign bar_tgt = bar_valid ? bar_map(bar_cmask, bar_mmask, r.ctrl[`MSQ_CTRL_PROMO])
                               : ST_IDLE;
    // A flush waits like a store under a full barrier
    assign eff = flush_valid ? ST_FLUSH : stronger(r.state, bar_tgt);

    // Address and space class play no part in draining
    assign drain_done = sb_empty && mem_idle;
    assign all_done   = drain_done && pipe_idle && !fault_pending;

    always_comb begin
        case (eff)
            ST_IDLE:  blocked = 1'b0;
            ST_LOOK:  blocked = mem_req_load && sb_addr_match;
            ST_DRAIN: blocked = 1'b1;
            ST_SYNC:  blocked = 1'b1;
            ST_FLUSH: blocked = 1'b1;
            default:  blocked = 1'b1;
        endcase
    end

    always_comb begin
        case (r.state)
            ST_LOOK:  fin = sb_empty;
            ST_DRAIN: fin = drain_done;
            ST_SYNC:  fin = all_done;
            ST_FLUSH: fin = all_done;
            default:  fin = 1'b0;
        endcase
    end

    assign st_go = mem_req_valid && mem_req_store && !blocked && !nf_fault;
    assign fence = (eff == ST_SYNC) || (eff == ST_FLUSH);

    msq_nf_check u_nf (
        .asi                    (mem_req_asi),
        .is_load                (mem_req_load),
        .is_store               (mem_req_store),
        .side_effect_page_bit   (side_effect_page_bit),
        .nonfault_only_page_bit (nonfault_only_page_bit),
        .is_nf                  (nf_is),
        .fault                  (nf_fault)
    );

    msq_merge u_merge (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .st_go        (st_go),
        .st_cacheable (page_cacheable),
        .st_side_eff  (side_effect_page_bit),
        .st_dw        (mem_req_dw),
        .merge_en     (r.ctrl[`MSQ_CTRL_MERGE]),
        .fence        (fence),
        .merge_ok     (merge_ok)
    );

    always_comb begin
        n            = r;
        n.rdata      = 32'h0;
        n.mem_go     = 1'b0;
        n.mem_fault  = 1'b0;
        n.mem_retry  = 1'b0;
        n.st_merge   = 1'b0;
        n.pipe_flush = 1'b0;
        n.icache_inv = 1'b0;

        if (reg_wr && reg_addr == `MSQ_REG_CTRL)
            n.ctrl = reg_wdata[2:0];
        if (reg_rd) begin
            case (reg_addr)
                `MSQ_REG_CTRL: n.rdata = {29'h0, r.ctrl};
                `MSQ_REG_STAT: n.rdata = {25'h0, r.instr_hold, r.mem_hold,
                                          r.no_fwd, r.inv_all, r.state};
                `MSQ_REG_CNT:  n.rdata = {16'h0, r.flt_cnt, r.bar_cnt};
                default:       n.rdata = 32'h0;
            endcase
        end

        n.state = eff;
        if (bar_valid && bar_tgt != ST_IDLE)
            n.bar_cnt = r.bar_cnt + 8'h01;
        if (flush_valid)
            n.flush_dw = flush_dw;

        // A grant still in flight may not yet show in the status inputs
        if (fin && !r.mem_go && eff == r.state) begin
            n.state = ST_IDLE;
            if (r.state == ST_FLUSH) begin
                n.pipe_flush = 1'b1;
                n.icache_inv = 1'b1;
                n.inv_all    = r.ctrl[`MSQ_CTRL_ICOH];
            end
        end

        // Held requests retry so no later fault shows early
        if (mem_req_valid) begin
            if (blocked)
                n.mem_retry = 1'b1;
            else if (nf_fault) begin
                n.mem_fault = 1'b1;
                n.flt_cnt   = r.flt_cnt + 8'h01;
            end else begin
                n.mem_go   = 1'b1;
                n.st_merge = mem_req_store && merge_ok;
            end
        end

        n.no_fwd     = (n.state == ST_LOOK);
        n.mem_hold   = (n.state == ST_DRAIN) || (n.state == ST_SYNC)
                    || (n.state == ST_FLUSH);
        n.instr_hold = (n.state == ST_SYNC) || (n.state == ST_FLUSH);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            r <= '{state: ST_IDLE, ctrl: `MSQ_CTRL_RST, default: '0};
        else
            r <= n;
    end

    assign reg_rdata      = r.rdata;
    assign mem_go         = r.mem_go;
    assign mem_fault      = r.mem_fault;
    assign mem_retry      = r.mem_retry;
    assign st_merge       = r.st_merge;
    assign no_fwd         = r.no_fwd;
    assign mem_hold       = r.mem_hold;
    assign instr_hold     = r.instr_hold;
    assign pipe_flush     = r.pipe_flush;
    assign icache_inv     = r.icache_inv;
    assign icache_inv_all = r.inv_all;
    assign icache_inv_dw  = r.flush_dw;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_look_nofwd: assert property (
        r.state == ST_IDLE && bar_valid && !flush_valid && bar_cmask == 3'h1
        && bar_mmask == 4'h0 && !r.ctrl[`MSQ_CTRL_PROMO] |=> no_fwd && !instr_hold)
        else $error("lookaside barrier left forwarding on");

    a_look_match: assert property (
        r.state == ST_LOOK && !bar_valid && !flush_valid && mem_req_valid
        && mem_req_load && sb_addr_match |=> mem_retry && !mem_go)
        else $error("load passed a same-address pending store");

    a_drain_block: assert property (
        r.state == ST_DRAIN && mem_req_valid |=> mem_retry && !mem_go && !mem_fault)
        else $error("memory op issued during drain");

    a_sync_hold: assert property (
        r.state == ST_SYNC && !all_done |=> instr_hold && mem_hold)
        else $error("sync released before completion");

    a_sync_release: assert property (
        r.state == ST_SYNC && all_done && !r.mem_go && !bar_valid && !flush_valid
        |=> !instr_hold && !mem_hold)
        else $error("sync hold not released");

    a_promote_sync: assert property (
        r.state == ST_IDLE && bar_valid && !flush_valid && bar_cmask == 3'h1
        && r.ctrl[`MSQ_CTRL_PROMO] |=> instr_hold)
        else $error("promoted lookaside did not synchronize");

    a_flush_order: assert property (
        pipe_flush |-> $past(sb_empty && mem_idle && pipe_idle))
        else $error("flush ended before earlier accesses");

    a_flush_pipe: assert property (
        flush_valid && r.state == ST_IDLE |=> instr_hold throughout
        (!pipe_flush [*1] ##0 instr_hold))
        else $error("flush did not hold issue");

    a_flush_coh: assert property (
        icache_inv |-> pipe_flush && icache_inv_all == $past(r.ctrl[`MSQ_CTRL_ICOH]))
        else $error("flush invalidate scope wrong");

    a_nf_side: assert property (
        mem_req_valid && mem_req_load && nf_is && side_effect_page_bit && !blocked
        |=> mem_fault && !mem_go)
        else $error("nonfaulting load to side-effect page not faulted");

    a_nf_store: assert property (
        mem_req_valid && mem_req_store && nf_is && !blocked |=> mem_fault)
        else $error("store in speculative space not faulted");

    a_side_nomerge: assert property (
        st_merge |-> $past(!side_effect_page_bit) && mem_go)
        else $error("side-effect store merged");

    // Barrier entry and release
    a_drain_entry: assert property (
        r.state == ST_IDLE && bar_valid && !flush_valid && bar_cmask == 3'h2
        && !r.ctrl[`MSQ_CTRL_PROMO]
        |=> mem_hold && !instr_hold && !no_fwd)
        else $error("issue drain barrier not entered");

    a_order_drain: assert property (
        r.state == ST_IDLE && bar_valid && !flush_valid && bar_mmask[`MSQ_MM_STLD]
        |=> mem_hold)
        else $error("store-load ordering did not hold issue");

    a_look_clear: assert property (
        r.state == ST_LOOK && sb_empty && !r.mem_go && !bar_valid && !flush_valid
        |=> !no_fwd)
        else $error("lookaside hold not released");

    a_look_other: assert property (
        r.state == ST_LOOK && !bar_valid && !flush_valid && mem_req_valid
        && !sb_addr_match && !nf_fault
        |=> mem_go)
        else $error("unrelated access held under lookaside");

    a_sync_fault: assert property (
        r.state == ST_SYNC && fault_pending
        |=> instr_hold && mem_hold)
        else $error("sync released with a fault pending");

    a_sync_issue: assert property (
        r.state == ST_SYNC && mem_req_valid
        |=> mem_retry && !mem_go)
        else $error("access issued during sync");

    // Flush sequencing
    a_flush_enter: assert property (
        flush_valid && r.state != ST_FLUSH
        |=> mem_hold && instr_hold)
        else $error("flush did not wait like a store");

    a_flush_dw: assert property (
        flush_valid && r.state != ST_FLUSH
        |=> icache_inv_dw == $past(flush_dw))
        else $error("flush address not captured");

    a_flush_release: assert property (
        pipe_flush
        |-> (icache_inv && !instr_hold && !mem_hold) ##1 !pipe_flush)
        else $error("flush pulse wrong");

    // Page checks and answers
    a_nfo_fault: assert property (
        mem_req_valid && nonfault_only_page_bit && !(mem_req_load && nf_is) && !blocked
        |=> mem_fault && !mem_go)
        else $error("access to nonfault-only page not faulted");

    a_nfo_load: assert property (
        mem_req_valid && mem_req_load && nf_is && nonfault_only_page_bit
        && !side_effect_page_bit && !blocked
        |=> mem_go && !mem_fault)
        else $error("nonfaulting load refused");

    a_plain_store: assert property (
        mem_req_valid && mem_req_store && !nf_is && !nonfault_only_page_bit && !blocked
        |=> !mem_fault)
        else $error("ordinary store faulted");

    a_one_answer: assert property (
        mem_req_valid
        |=> $onehot({mem_go, mem_fault, mem_retry}))
        else $error("request not answered exactly once");

    a_no_answer: assert property (
        !mem_req_valid
        |=> !mem_go && !mem_fault && !mem_retry)
        else $error("answer without a request");

    // Store merging
    a_merge_enable: assert property (
        st_merge
        |-> $past(r.ctrl[`MSQ_CTRL_MERGE]) && $past(mem_req_store))
        else $error("merge while disabled or not a store");

    a_sync_nomerge: assert property (
        r.state == ST_SYNC ##1 mem_req_valid
        |=> !st_merge)
        else $error("store merged across sync");

    c_sync_done: cover property (r.state == ST_SYNC ##1 r.state == ST_IDLE);
    c_look_retry: cover property (mem_retry && no_fwd);
    c_merge_pair: cover property (st_merge ##1 st_merge);
    c_flush_done: cover property (pipe_flush && !icache_inv_all);
    c_drain_retry: cover property (mem_retry && mem_hold && !instr_hold);
endmodule // msq_seq_ctrl

// File: rtl/msq_consts.svh
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
// What this block does
// - Lookaside barrier: loads bypass write buffer
// - Lookaside: same-address store completes first
// - Issue drain: earlier memory ops finish first
// - Sync: all earlier work and faults settle
// - Sequencing mask bits 0,1,2 select barriers
// - Lookaside and drain may run as sync
// - Flushed fetches follow earlier same-address accesses
// - Flush counts as store for barriers
// - Flush synchronizes and empties instruction pipeline
// - Coherent memories: flush address may be ignored
// - Nonfaulting load to side-effect page faults
// - Nonfault-only page faults all other accesses
// - Nonfaulting loads known by speculative space class
// - Store with speculative space class faults
// - Cacheable stores merge within aligned doubleword
// - Plain noncacheable stores merge likewise
// - Side-effect stores never merge
// - No merge across full sync barrier
// - One barrier may request ordering and sequencing
// - Barriers cover all own pending operations

// Register offsets
`define MSQ_REG_CTRL 4'h0
`define MSQ_REG_STAT 4'h4
`define MSQ_REG_CNT  4'h8

// Control register fields and reset value
`define MSQ_CTRL_RST   3'h4
`define MSQ_CTRL_PROMO 0
`define MSQ_CTRL_ICOH  1
`define MSQ_CTRL_MERGE 2

// Barrier mask bits
`define MSQ_CM_LOOK  0
`define MSQ_CM_ISSUE 1
`define MSQ_CM_SYNC  2
`define MSQ_MM_STLD  1

// Speculative address space classes
`define MSQ_PRIMARY_SPEC_SPACE    8'hA0
`define MSQ_SECONDARY_SPEC_SPACE  8'hA1
`define MSQ_PRIMARY_SPEC_SPACE_L  8'hA8
`define MSQ_SECONDARY_SPEC_SPACE_L 8'hA9

// Doubleword index width of a 64-bit address
`define MSQ_DW_W 61
`endif

// File: rtl/msq_pkg.sv
`include "msq_consts.svh"
package msq_pkg;
    // Codes are ordered by strength; the controller compares them
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOOK  = 3'b001,
        ST_DRAIN = 3'b010,
        ST_SYNC  = 3'b011,
        ST_FLUSH = 3'b100
    } msq_state_t;

    typedef struct packed {
        msq_state_t           state;
        logic [2:0]           ctrl;
        logic [31:0]          rdata;
        logic [7:0]           bar_cnt;
        logic [7:0]           flt_cnt;
        logic                 mem_go;
        logic                 mem_fault;
        logic                 mem_retry;
        logic                 st_merge;
        logic                 no_fwd;
        logic                 mem_hold;
        logic                 instr_hold;
        logic                 pipe_flush;
        logic                 icache_inv;
        logic                 inv_all;
        logic [`MSQ_DW_W-1:0] flush_dw;
    } msq_top_t;

    typedef struct packed {
        logic                 valid;
        logic                 cacheable;
        logic [`MSQ_DW_W-1:0] dw;
    } msq_merge_t;
endpackage

// File: rtl/msq_nf_check.sv
`include "msq_consts.svh"
module msq_nf_check (
    // Access attributes
    input  logic [7:0] asi,
    input  logic       is_load,
    input  logic       is_store,
    input  logic       side_effect_page_bit,
    input  logic       nonfault_only_page_bit,
    // Verdict
    output logic       is_nf,
    output logic       fault
);
    logic nf_load;

    function automatic logic nf_space(input logic [7:0] a);
        return (a == `MSQ_PRIMARY_SPEC_SPACE) || (a == `MSQ_SECONDARY_SPEC_SPACE)
            || (a == `MSQ_PRIMARY_SPEC_SPACE_L) || (a == `MSQ_SECONDARY_SPEC_SPACE_L);
    endfunction

    assign is_nf   = nf_space(asi);
    assign nf_load = is_nf && is_load;
    assign fault   = (nf_load && side_effect_page_bit)
                   || (nonfault_only_page_bit && !nf_load)
                   || (is_nf && is_store);
endmodule // msq_nf_check

// File: rtl/msq_merge.sv
`include "msq_consts.svh"
module msq_merge
    import msq_pkg::*;
(
    // Clock and reset
    input  logic                 sys_clk,
    input  logic                 rst_n,
    // Store leaving for the buffer
    input  logic                 st_go,
    input  logic                 st_cacheable,
    input  logic                 st_side_eff,
    input  logic [`MSQ_DW_W-1:0] st_dw,
    // Control
    input  logic                 merge_en,
    input  logic                 fence,
    output logic                 merge_ok
);
    msq_merge_t r, n;

    // Same aligned doubleword, same kind of memory
    assign merge_ok = merge_en && r.valid && !st_side_eff
                    && (r.dw == st_dw)
                    && (r.cacheable == st_cacheable);

    always_comb begin
        n = r;
        if (st_go) begin
            // A side-effect store is no merge target either
            n.valid     = !st_side_eff;
            n.cacheable = st_cacheable;
            n.dw        = st_dw;
        end
        if (fence)
            n.valid = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            r <= '0;
        else
            r <= n;
    end
endmodule // msq_merge

// File: verification/msq_sb_model.sv
`include "msq_consts.svh"
module msq_sb_model (
    // Clock and reset
    input  logic                 sys_clk,
    input  logic                 rst_n,
    // Requests at issue and their grants
    input  logic                 mem_req_valid,
    input  logic                 mem_req_store,
    input  logic [`MSQ_DW_W-1:0] mem_req_dw,
    input  logic                 mem_go,
    // Drain time of a granted store; zero answers at once
    input  logic [7:0]           lat,
    // Status back to the controller
    output logic                 sb_empty,
    output logic                 mem_idle,
    output logic                 sb_addr_match
);
    timeunit 1ns;
    timeprecision 100ps;
    logic                 was_st;
    logic [7:0]           cnt;
    logic [`MSQ_DW_W-1:0] req_dw;
    logic [`MSQ_DW_W-1:0] st_dw;

    // Only the newest store is tracked; it restarts the drain time
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            was_st <= 1'b0;
            cnt    <= 8'h00;
            req_dw <= '0;
            st_dw  <= '0;
        end else begin
            was_st <= mem_req_valid & mem_req_store;
            if (mem_req_valid & mem_req_store)
                req_dw <= mem_req_dw;
            if (mem_go & was_st & (lat != 8'h00)) begin
                cnt   <= lat;
                st_dw <= req_dw;
            end else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end

    assign sb_empty      = (cnt == 8'h00);
    assign mem_idle      = (cnt == 8'h00);
    assign sb_addr_match = (cnt != 8'h00) && (mem_req_dw == st_dw);
endmodule // msq_sb_model

// File: verification/memory_sequencing_and_store_merge_tb_top.sv
`include "msq_consts.svh"
module memory_sequencing_and_store_merge_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 sys_clk, rst_n, reg_wr, reg_rd, bar_valid, flush_valid;
    logic [3:0]           reg_addr, bar_mmask;
    logic [31:0]          reg_wdata, reg_rdata;
    logic [2:0]           bar_cmask;
    logic [`MSQ_DW_W-1:0] flush_dw, mem_req_dw, icache_inv_dw;
    logic                 mem_req_valid, mem_req_load, mem_req_store;
    logic [7:0]           mem_req_asi, lat;
    logic                 side_effect_page_bit, nonfault_only_page_bit, page_cacheable;
    logic                 sb_empty, sb_addr_match, mem_idle, pipe_idle, fault_pending;
    logic                 mem_go, mem_fault, mem_retry, st_merge, no_fwd, mem_hold;
    logic                 instr_hold, pipe_flush, icache_inv, icache_inv_all;
    logic [7:0]           nf [4] = '{`MSQ_PRIMARY_SPEC_SPACE, `MSQ_SECONDARY_SPEC_SPACE,
                                     `MSQ_PRIMARY_SPEC_SPACE_L, `MSQ_SECONDARY_SPEC_SPACE_L};
    int                   fails = 0;
    int                   cmp_count = 0;

    msq_seq_ctrl u_msq_seq_ctrl (
        .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .bar_valid, .bar_cmask, .bar_mmask, .flush_valid, .flush_dw,
        .mem_req_valid, .mem_req_load, .mem_req_store, .mem_req_asi, .mem_req_dw,
        .side_effect_page_bit, .nonfault_only_page_bit, .page_cacheable,
        .sb_empty, .sb_addr_match, .mem_idle, .pipe_idle, .fault_pending,
        .mem_go, .mem_fault, .mem_retry, .st_merge, .no_fwd, .mem_hold, .instr_hold,
        .pipe_flush, .icache_inv, .icache_inv_all, .icache_inv_dw
    );
    msq_sb_model u_msq_sb_model (
        .sys_clk, .rst_n, .mem_req_valid, .mem_req_store, .mem_req_dw, .mem_go, .lat,
        .sb_empty, .mem_idle, .sb_addr_match
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask

    // Page attributes pg are {side effect, nonfault only, cacheable}
    task automatic req(input logic st, input logic [7:0] asi, input logic [60:0] dw,
                       input logic [2:0] pg, input logic [3:0] exp);
        @(posedge sys_clk);
        mem_req_valid <= 1'b1;
        mem_req_load <= !st;
        mem_req_store <= st;
        mem_req_asi <= asi;
        mem_req_dw <= dw;
        {side_effect_page_bit, nonfault_only_page_bit, page_cacheable} <= pg;
        @(posedge sys_clk);
        mem_req_valid <= 1'b0;
        @(negedge sys_clk);
        chk({mem_go, mem_fault, mem_retry, st_merge}, exp);
    endtask

    task automatic bar(input logic [2:0] cm, input logic [3:0] mm);
        @(posedge sys_clk);
        bar_valid <= 1'b1;
        bar_cmask <= cm;
        bar_mmask <= mm;
        @(posedge sys_clk);
        bar_valid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic settle();
        int n = 0;
        while ((instr_hold | mem_hold | no_fwd) !== 1'b0 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        chk(sb_empty & mem_idle, 1'b1);
        chk(n == 60, 1'b0);
        if (n == 60) tally_and_finish();
    endtask

    task automatic fl(input logic [60:0] dw, input logic all);
        int n = 0;
        @(posedge sys_clk);
        flush_valid <= 1'b1;
        flush_dw <= dw;
        @(posedge sys_clk);
        flush_valid <= 1'b0;
        @(negedge sys_clk);
        chk(instr_hold, 1'b1);
        while (pipe_flush !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        chk(sb_empty, 1'b1);
        chk({icache_inv, icache_inv_all, icache_inv_dw}, {1'b1, all, dw});
        chk(n == 60, 1'b0);
        if (n == 60) tally_and_finish();
        @(negedge sys_clk);
        chk(pipe_flush, 1'b0);
    endtask

    initial begin
        {rst_n, reg_wr, reg_rd, bar_valid, flush_valid, mem_req_valid} = '0;
        {reg_addr, reg_wdata, bar_cmask, bar_mmask, flush_dw, mem_req_dw} = '0;
        {mem_req_load, mem_req_store, mem_req_asi, fault_pending, lat} = '0;
        {side_effect_page_bit, nonfault_only_page_bit, page_cacheable} = '0;
        pipe_idle = 1'b1;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(4'h0, 32'h4);
        rd(4'h4, 32'h0);
        wr(4'h4, 32'h7F);
        wr(4'hC, 32'h1);
        rd(4'h4, 32'h0);
        rd(4'hC, 32'h0);
        wr(4'h0, 32'hFFFF_FFFF);
        rd(4'h0, 32'h7);
        wr(4'h0, 32'h4);
        // Store merging, store buffer answering at once
        req(1, 8'h80, 61'h8, 3'b001, 4'b1000);
        req(1, 8'h80, 61'h8, 3'b001, 4'b1001);
        req(1, 8'h80, 61'h8, 3'b000, 4'b1000);
        req(1, 8'h80, 61'h8, 3'b000, 4'b1001);
        req(1, 8'h80, 61'h9, 3'b000, 4'b1000);
        req(1, 8'h80, 61'h9, 3'b100, 4'b1000);
        req(1, 8'h80, 61'h9, 3'b100, 4'b1000);
        req(1, 8'h80, 61'h9, 3'b001, 4'b1000);
        bar(3'h4, 4'h0);
        chk(instr_hold, 1'b1);
        settle();
        req(1, 8'h80, 61'h9, 3'b001, 4'b1000);
        wr(4'h0, 32'h0);
        req(1, 8'h80, 61'h9, 3'b001, 4'b1000);
        wr(4'h0, 32'h4);
        // Speculative loads and page checks
        for (int i = 0; i < 4; i++) begin
            req(0, nf[i], 61'h20, 3'b101, 4'b0100);
            req(0, nf[i], 61'h20, 3'b011, 4'b1000);
            req(1, nf[i], 61'h20, 3'b001, 4'b0100);
        end
        req(0, 8'h80, 61'h20, 3'b011, 4'b0100);
        req(0, 8'hA2, 61'h20, 3'b101, 4'b1000);
        // Barriers against a slow store buffer
        lat = 8'd20;
        req(1, 8'h80, 61'h5, 3'b001, 4'b1000);
        bar(3'h1, 4'h0);
        chk(no_fwd, 1'b1);
        rd(4'h4, 32'h11);
        req(0, 8'h80, 61'h5, 3'b001, 4'b0010);
        req(0, 8'h80, 61'h6, 3'b001, 4'b1000);
        settle();
        req(1, 8'h80, 61'h5, 3'b001, 4'b1001);
        bar(3'h2, 4'h0);
        chk(mem_hold, 1'b1);
        req(1, 8'h80, 61'hA, 3'b001, 4'b0010);
        settle();
        req(1, 8'h80, 61'h5, 3'b001, 4'b1001);
        bar(3'h1, 4'h2);
        chk(mem_hold, 1'b1);
        req(0, 8'h80, 61'h7, 3'b001, 4'b0010);
        settle();
        req(1, 8'h80, 61'h5, 3'b001, 4'b1001);
        @(posedge sys_clk);
        fault_pending <= 1'b1;
        bar(3'h4, 4'h0);
        chk({instr_hold, mem_hold}, 2'b11);
        req(0, 8'h80, 61'h7, 3'b001, 4'b0010);
        for (int n = 0; n < 60 && sb_empty !== 1'b1; n++) @(negedge sys_clk);
        chk(sb_empty, 1'b1);
        repeat (3) @(negedge sys_clk);
        chk(instr_hold, 1'b1);
        @(posedge sys_clk);
        fault_pending <= 1'b0;
        settle();
        wr(4'h0, 32'h5);
        req(1, 8'h80, 61'h5, 3'b001, 4'b1000);
        bar(3'h1, 4'h0);
        chk(instr_hold, 1'b1);
        settle();
        wr(4'h0, 32'h4);
        // Instruction-stream flush behind a pending store
        req(1, 8'h80, 61'h33, 3'b001, 4'b1000);
        fl(61'h33, 1'b0);
        wr(4'h0, 32'h6);
        fl(61'h44, 1'b1);
        rd(4'h4, 32'h8);
        rd(4'h8, 32'h906);
        tally_and_finish();
    end
endmodule // memory_sequencing_and_store_merge_tb_top
